// file: verilog/sdmrs_pkg.sv
//Contract
//- setting the mode-set trigger runs one bus cycle loading the sdram mode register; the code drops it without a prior precharge or on a miss.
//- first cycle after trigger drives the mode value on sdram a[10:0].
//- sdram a10..a7=cpu a20..a17, a6..a4=a9,a10,a11, a3..a0=a12..a15.
//- mode-set address bits 31:20 equal the programmed base address; the code skips bits whose mask bit is set.
//- bit 19 must be one, else the sdram is not selected; the code matches it to base bit 19 unless mask bit 19 is set.
//- trigger reads zero when no mode-set command is started.
package sdmrs_pkg;
    localparam logic [3:0]  REG_REFRESH_CTRL  = 4'h0;
    localparam logic [3:0]  REG_ADDR_CTRL     = 4'h4;
    localparam logic [3:0]  REG_ADDR_MASK     = 4'h8;
    localparam logic [3:0]  REG_MODE_ADDR     = 4'hC;
    localparam logic [3:0]  REG_STATUS        = 4'h0 + 4'h0;
    localparam logic [31:0] RST_REFRESH_CTRL  = 32'h0000_0000;
    localparam logic [31:0] RST_ADDR_CTRL     = 32'h0000_0000;
    localparam logic [31:0] RST_ADDR_MASK     = 32'h0000_0000;
    localparam int          ACR_PRECHARGE_BIT = 3;
    localparam int          ACR_TRIGGER_BIT   = 6;
    localparam int          BASE_LSB          = 20;
    localparam int          MATCH_BIT         = 19;
    localparam int          MASK_LSB          = 16;
    localparam int          RD_WIDTH          = 32;
    localparam int          MODE_WIDTH        = 11;
    localparam int          PRECHARGE_CYCLES  = 2;
    typedef enum logic [1:0] {SDMRS_IDLE, SDMRS_PRECH, SDMRS_MODE} sdmrs_state_t;
endpackage : sdmrs_pkg

// file: verilog/sdmrs_addr_map.sv
// pure wiring from processor address to sdram mode lines
module sdmrs_addr_map
    import sdmrs_pkg::*;
(
    input  wire logic [31:0]           cpu_addr_i,  // processor address
    output logic      [MODE_WIDTH-1:0] mode_o       // sdram a[10:0]
);
    always_comb
    begin
        mode_o[10:7] = cpu_addr_i[20:17];
        mode_o[6]    = cpu_addr_i[9];
        mode_o[5]    = cpu_addr_i[10];
        mode_o[4]    = cpu_addr_i[11];
        mode_o[3]    = cpu_addr_i[12];
        mode_o[2]    = cpu_addr_i[13];
        mode_o[1]    = cpu_addr_i[14];
        mode_o[0]    = cpu_addr_i[15];
    end
endmodule : sdmrs_addr_map

// file: verilog/sdmrs_top.sv
// Local design decisions: strobed register access and the address map.
module sdmrs_top
    import sdmrs_pkg::*;
(
    input  wire logic                  core_clk_i,  // 10 mhz bus clock
    input  wire logic                  rst_n_i,     // async reset, active low
    input  wire logic                  clk_en_i,    // freezes all state but the reset synchronizer when low
    input  wire logic [3:0]            reg_addr_i,  // register byte offset
    input  wire logic [31:0]           reg_wdata_i, // write data
    input  wire logic                  reg_wr_i,    // write strobe
    input  wire logic                  reg_rd_i,    // read strobe
    output logic      [31:0]           reg_rdata_o, // read data, cycle after strobe
    output logic      [MODE_WIDTH-1:0] sdram_a_o,   // sdram address a[10:0]
    output logic                       sdram_mrs_o, // mode-register-set command cycle
    output logic                       sdram_pre_o, // precharge-all command cycle
    output logic                       sdram_cs_o,  // sdram chip select
    output logic                       mode_hit_o   // mode-set address hits sdram region
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // the line map is hard wired for eleven sdram address lines
    if (MODE_WIDTH != 11)
    begin : g_bad_mode_width
        $error("mode width must be 11");
    end

    // the match compare below is written for a sixteen bit field
    if (MASK_LSB != 16 || MATCH_BIT < MASK_LSB || MATCH_BIT > 31)
    begin : g_bad_match
        $error("match field out of range");
    end

    // the precharge counter is only two bits wide
    if (PRECHARGE_CYCLES < 1 || PRECHARGE_CYCLES > 4)
    begin : g_bad_precharge
        $error("precharge length out of range");
    end

    // trigger and precharge share one register and must not overlap
    if (ACR_TRIGGER_BIT == ACR_PRECHARGE_BIT || ACR_TRIGGER_BIT > 31 || ACR_PRECHARGE_BIT > 31)
    begin : g_bad_ctrl_bits
        $error("control bit positions out of range");
    end

    // every register and the read path are one 32 bit word
    if (RD_WIDTH != 32)
    begin : g_bad_rd_width
        $error("read width must be 32");
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset release

    logic rst_s1_r;
    logic rst_n_r;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [31:0]      refresh_r, refresh_nxt;
    logic [31:0]      acr_r, acr_nxt;
    logic [31:0]      mask_r, mask_nxt;
    logic [31:0]      mode_addr_r, mode_addr_nxt;
    logic [31:0]      rdata_r, rdata_nxt;
    logic             banks_idle_r, banks_idle_nxt;
    sdmrs_state_t     state_r, state_nxt;
    logic [1:0]       cnt_r, cnt_nxt;
    logic [MODE_WIDTH-1:0] mode_lines;
    logic [MODE_WIDTH-1:0] a_r, a_nxt;
    logic             mrs_r, mrs_nxt;
    logic             pre_r, pre_nxt;
    logic             hit;
    logic             trig_set;
    logic             pre_set;

    sdmrs_addr_map sdmrs_addr_map_inst (
        .cpu_addr_i (mode_addr_r),
        .mode_o     (mode_lines)
    );

    // base address match, masked bits ignored; bit 19 must hit unless masked
    always_comb
    begin
        hit = (((mode_addr_r[31:MASK_LSB] ^ acr_r[31:MASK_LSB]) & ~mask_r[31:MASK_LSB]) == 16'h0000);
    end

    always_comb
    begin
        trig_set = reg_wr_i && (reg_addr_i == REG_ADDR_CTRL) && reg_wdata_i[ACR_TRIGGER_BIT];
        pre_set  = reg_wr_i && (reg_addr_i == REG_ADDR_CTRL) && reg_wdata_i[ACR_PRECHARGE_BIT];
    end

    always_comb
    begin
        refresh_nxt    = refresh_r;
        acr_nxt        = acr_r;
        mask_nxt       = mask_r;
        mode_addr_nxt  = mode_addr_r;
        rdata_nxt      = 32'h0000_0000;
        state_nxt      = state_r;
        cnt_nxt        = cnt_r;
        banks_idle_nxt = banks_idle_r;
        a_nxt          = a_r;
        mrs_nxt        = 1'b0;
        pre_nxt        = 1'b0;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                REG_REFRESH_CTRL: refresh_nxt   = reg_wdata_i;
                REG_ADDR_CTRL:    acr_nxt       = reg_wdata_i;
                REG_ADDR_MASK:    mask_nxt      = reg_wdata_i;
                REG_MODE_ADDR:    mode_addr_nxt = reg_wdata_i;
                default:          ;
            endcase
        end
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                REG_REFRESH_CTRL: rdata_nxt = refresh_r;
                REG_ADDR_CTRL:    rdata_nxt = acr_r;
                REG_ADDR_MASK:    rdata_nxt = mask_r;
                REG_MODE_ADDR:    rdata_nxt = mode_addr_r;
                default:          rdata_nxt = 32'h0000_0000;
            endcase
        end
        case (state_r)
            SDMRS_IDLE:
            begin
                if (acr_r[ACR_PRECHARGE_BIT])
                begin
                    state_nxt = SDMRS_PRECH;
                    cnt_nxt   = 2'(PRECHARGE_CYCLES - 1);
                    pre_nxt   = 1'b1;
                end
                else if (acr_r[ACR_TRIGGER_BIT])
                begin
                    // a trigger without precharge or outside the region is dropped
                    if (banks_idle_r && hit)
                    begin
                        state_nxt = SDMRS_MODE;
                        a_nxt     = mode_lines;
                        mrs_nxt   = 1'b1;
                    end
                    if (!trig_set)
                        acr_nxt[ACR_TRIGGER_BIT] = 1'b0;
                end
            end
            SDMRS_PRECH:
            begin
                if (cnt_r == 2'h0)
                begin
                    state_nxt      = SDMRS_IDLE;
                    banks_idle_nxt = 1'b1;
                    if (!pre_set)
                        acr_nxt[ACR_PRECHARGE_BIT] = 1'b0;
                end
                else
                    cnt_nxt = cnt_r - 2'h1;
            end
            SDMRS_MODE:
            begin
                // one command cycle only
                state_nxt = SDMRS_IDLE;
                a_nxt     = '0;
            end
            default: state_nxt = SDMRS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            refresh_r    <= RST_REFRESH_CTRL;
            acr_r        <= RST_ADDR_CTRL;
            mask_r       <= RST_ADDR_MASK;
            mode_addr_r  <= 32'h0000_0000;
            rdata_r      <= 32'h0000_0000;
            state_r      <= SDMRS_IDLE;
            cnt_r        <= 2'h0;
            // bank state is unknown after reset, so a mode set first needs a precharge
            banks_idle_r <= 1'b0;
            a_r          <= '0;
            mrs_r        <= 1'b0;
            pre_r        <= 1'b0;
        end
        // enable low holds every register; strobes seen then are lost, not queued
        else if (clk_en_i)
        begin
            refresh_r    <= refresh_nxt;
            acr_r        <= acr_nxt;
            mask_r       <= mask_nxt;
            mode_addr_r  <= mode_addr_nxt;
            rdata_r      <= rdata_nxt;
            state_r      <= state_nxt;
            cnt_r        <= cnt_nxt;
            banks_idle_r <= banks_idle_nxt;
            a_r          <= a_nxt;
            mrs_r        <= mrs_nxt;
            pre_r        <= pre_nxt;
        end
    end

    always_comb
    begin
        reg_rdata_o = rdata_r;
        sdram_a_o   = a_r;
        sdram_mrs_o = mrs_r;
        sdram_pre_o = pre_r;
        sdram_cs_o  = mrs_r | pre_r;
        mode_hit_o  = hit;
    end

endmodule : sdmrs_top

// file: tb/sdmrs_props.sv
module sdmrs_props
    import sdmrs_pkg::*;
(
    input wire logic                  core_clk_i,  // clock
    input wire logic                  rst_n_i,     // reset
    input wire logic [3:0]            reg_addr_i,  // offset
    input wire logic [31:0]           reg_wdata_i, // wdata
    input wire logic                  reg_wr_i,    // write
    input wire logic [MODE_WIDTH-1:0] sdram_a_o,   // lines
    input wire logic                  sdram_mrs_o, // mode set
    input wire logic                  sdram_pre_o, // precharge
    input wire logic                  sdram_cs_o,  // select
    input wire logic                  mode_hit_o   // hit
);
    logic        trig_wr;
    logic        pre_wr;
    logic [31:0] maddr_r;
    assign trig_wr = reg_wr_i && reg_addr_i == REG_ADDR_CTRL && reg_wdata_i[ACR_TRIGGER_BIT];
    assign pre_wr  = reg_wr_i && reg_addr_i == REG_ADDR_CTRL && reg_wdata_i[ACR_PRECHARGE_BIT];
    // shadow of the mode-set address, so the line mapping can be judged
    always_ff @(posedge core_clk_i or negedge rst_n_i)
        if (!rst_n_i) maddr_r <= 32'h0;
        else if (reg_wr_i && reg_addr_i == REG_MODE_ADDR) maddr_r <= reg_wdata_i;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    mrs_single_a: assert property (sdram_mrs_o |=> !sdram_mrs_o) else $error("mode set too long");
    mrs_cause_a: assert property (sdram_mrs_o |-> $past(trig_wr) || $past(trig_wr, 2) || $past(trig_wr, 3))
        else $error("mode set without trigger");
    mrs_hit_a: assert property (sdram_mrs_o |-> $past(mode_hit_o)) else $error("mode set on miss");
    lines_map_a: assert property (sdram_mrs_o |-> sdram_a_o == {maddr_r[20:17], maddr_r[9], maddr_r[10],
        maddr_r[11], maddr_r[12], maddr_r[13], maddr_r[14], maddr_r[15]}) else $error("bad line map");
    lines_quiet_a: assert property (!sdram_mrs_o |-> sdram_a_o == '0) else $error("lines driven");
    cs_match_a: assert property (sdram_cs_o == (sdram_mrs_o || sdram_pre_o)) else $error("bad select");
    cmd_excl_a: assert property (!(sdram_mrs_o && sdram_pre_o)) else $error("two commands");
    pre_cause_a: assert property ($rose(sdram_pre_o) |-> $past(pre_wr) || $past(pre_wr, 2) ||
        $past(pre_wr, 3)) else $error("precharge without request");
    cover property (sdram_mrs_o);
    cover property (sdram_pre_o);
    cover property (trig_wr && !mode_hit_o);
endmodule : sdmrs_props
////////////////////////////////////////////////////////////////
bind sdmrs_top sdmrs_props sdmrs_props_inst (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .sdram_a_o, .sdram_mrs_o, .sdram_pre_o, .sdram_cs_o, .mode_hit_o);

// file: tb/sdmrs_sdram_model.sv
module sdmrs_sdram_model
    import sdmrs_pkg::*;
(
    input wire logic                  clk_i,  // bus clock
    input wire logic                  cs_i,   // select
    input wire logic                  mrs_i,  // mode set
    input wire logic                  pre_i,  // precharge
    input wire logic [MODE_WIDTH-1:0] a_i,    // lines
    output logic      [MODE_WIDTH-1:0] mode_o, // latched mode
    output logic                       err_o   // mode set while banks open
);
    logic                  idle_r = 1'b0;
    logic [MODE_WIDTH-1:0] mode_r = '0;
    logic                  err_r  = 1'b0;
    assign mode_o = mode_r;
    assign err_o  = err_r;
    always @(posedge clk_i)
    begin
        if (cs_i && pre_i) idle_r <= 1'b1;
        if (cs_i && mrs_i) mode_r <= a_i;
        if (cs_i && mrs_i && !idle_r) err_r <= 1'b1;
    end
endmodule : sdmrs_sdram_model

// file: tb/sdmrs_top_bench.sv
module sdmrs_top_bench;
    import sdmrs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, clk_en_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
    logic [MODE_WIDTH-1:0] sdram_a_o, mode_seen;
    logic sdram_mrs_o, sdram_pre_o, sdram_cs_o, mode_hit_o, model_err;
    int n_errors = 0, checks = 0;
    int pos[11] = '{17, 18, 19, 20, 9, 10, 11, 12, 13, 14, 15};
    sdmrs_top sdmrs_top_inst (.core_clk_i, .rst_n_i, .clk_en_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .sdram_a_o, .sdram_mrs_o, .sdram_pre_o, .sdram_cs_o, .mode_hit_o);
    sdmrs_sdram_model sdmrs_sdram_model_inst (.clk_i(core_clk_i), .cs_i(sdram_cs_o), .mrs_i(sdram_mrs_o),
        .pre_i(sdram_pre_o), .a_i(sdram_a_o), .mode_o(mode_seen), .err_o(model_err));
    initial forever #50 core_clk_i = ~core_clk_i;
    task check(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task wr(logic [3:0] a, logic [31:0] d);
        @(posedge core_clk_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task rd(logic [3:0] a, logic [31:0] exp);
        @(posedge core_clk_i);
        {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 check("read data", reg_rdata_o, exp);
    endtask : rd
    // counts pulses over a fixed window; a missing pulse is a mismatch, not a hang
    task trig(int exp_n, logic [10:0] exp_a);
        int n;
        n = 0;
        wr(REG_ADDR_CTRL, 32'hFF880340);
        repeat (6)
        begin
            @(posedge core_clk_i);
            #1 if (sdram_mrs_o === 1'b1) n++;
        end
        check("mode set count", n, exp_n);
        if (exp_n == 1) check("latched mode", mode_seen, exp_a);
        rd(REG_ADDR_CTRL, 32'hFF880300);
    endtask : trig
    function automatic logic [10:0] mapped(logic [31:0] x);
        return {x[20:17], x[9], x[10], x[11], x[12], x[13], x[14], x[15]};
    endfunction : mapped
    task reset_values;
        rd(REG_REFRESH_CTRL, 32'h0);
        rd(REG_ADDR_CTRL, 32'h0);
        rd(REG_ADDR_MASK, 32'h0);
        rd(4'h2, 32'h0);
    endtask : reset_values
    task power_up_order;
        wr(REG_REFRESH_CTRL, 32'h00008026);
        wr(REG_ADDR_CTRL, 32'hFF880300);
        wr(REG_ADDR_MASK, 32'h00740075);
        wr(REG_MODE_ADDR, 32'hFF800800);
        trig(0, 11'h0);
        wr(REG_ADDR_CTRL, 32'hFF880308);
        repeat (6) @(posedge core_clk_i);
        #1 check("hit, bit 19 unmasked", mode_hit_o, 1'b0);
        trig(0, 11'h0);
        wr(REG_ADDR_MASK, 32'h007C0075);
        #1 check("hit, bit 19 masked", mode_hit_o, 1'b1);
        trig(1, 11'h010);
    endtask : power_up_order
    // a write while the clock enable is low must leave the register untouched
    task freeze_hold;
        @(posedge core_clk_i);
        clk_en_i <= 1'b0;
        wr(REG_REFRESH_CTRL, 32'h0000ABCD);
        clk_en_i <= 1'b1;
        rd(REG_REFRESH_CTRL, 32'h00008026);
    endtask : freeze_hold
    task line_walk;
        logic [31:0] a;
        wr(REG_ADDR_MASK, 32'h007E0075);
        foreach (pos[i])
        begin
            a = 32'hFF800000 | (32'h1 << pos[i]);
            wr(REG_MODE_ADDR, a);
            trig(1, mapped(a));
        end
        check("partner order", model_err, 1'b0);
    endtask : line_walk
    task end_of_test;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (6) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        reset_values();
        power_up_order();
        freeze_hold();
        line_walk();
        end_of_test();
    end
endmodule : sdmrs_top_bench
